// File: inc/exec_cfg.svh
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_RD 8'h04
`define OFS_RR 8'h08
`define OFS_ARG 8'h0c
`define OFS_DISP 8'h10
`define OFS_PC 8'h14
`define OFS_ZP 8'h18
`define OFS_FLAGS 8'h1c
`define OFS_STAT 8'h20
`define OFS_IODAT 8'h24
`define OFS_SP 8'h28

// Field positions
`define CTRL_GO_BIT 8
`define ARG_IO_LSB 8
`define ARG_TWO_BIT 16
`define STAT_CYC_LSB 4
`define STAT_BAD_BIT 8

// Flag positions in the flags register
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// Reset values and constants
`define RST_PC 16'h0000
`define RST_FLAGS 8'h00
`define ALL_ONES 8'hff

// Cycle counts
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR 3'h4

`endif

// File: inc/exec_pkg.sv
package exec_pkg;

   typedef enum logic [5:0] {
      OP_TEST_REGISTER = 6'b000000,
      OP_CLEAR_REGISTER = 6'b000001,
      OP_SET_REGISTER_ALL_ONES = 6'b000010,
      OP_RELATIVE_JUMP = 6'b000011,
      OP_INDIRECT_JUMP = 6'b000100,
      OP_RELATIVE_CALL = 6'b000101,
      OP_INDIRECT_CALL = 6'b000110,
      OP_SUBROUTINE_RETURN = 6'b000111,
      OP_INTERRUPT_RETURN = 6'b001000,
      OP_COMPARE_SKIP_EQUAL = 6'b001001,
      OP_COMPARE_REGS = 6'b001010,
      OP_COMPARE_REGS_WITH_CARRY = 6'b001011,
      OP_COMPARE_IMMEDIATE = 6'b001100,
      OP_SKIP_REG_BIT_CLEAR = 6'b001101,
      OP_SKIP_REG_BIT_SET = 6'b001110,
      OP_SKIP_IO_BIT_CLEAR = 6'b001111,
      OP_SKIP_IO_BIT_SET = 6'b010000,
      OP_BRANCH_FLAG_SET = 6'b010001,
      OP_BRANCH_FLAG_CLEAR = 6'b010010,
      OP_BRANCH_SIGNED_GE = 6'b010011,
      OP_BRANCH_SIGNED_LT = 6'b010100,
      OP_BRANCH_UNSIGNED_GE = 6'b010101,
      OP_BRANCH_UNSIGNED_LT = 6'b010110,
      OP_BRANCH_IRQ_ENABLED = 6'b010111,
      OP_BRANCH_IRQ_DISABLED = 6'b011000,
      OP_IO_BIT_SET_OP = 6'b011001,
      OP_IO_BIT_CLEAR_OP = 6'b011010,
      OP_SHIFT_LEFT_LOGICAL = 6'b011011,
      OP_SHIFT_RIGHT_LOGICAL = 6'b011100
   } op_e;

   typedef enum logic [2:0] {
      ALU_PASS = 3'b000,
      ALU_TEST = 3'b001,
      ALU_CLEAR = 3'b010,
      ALU_ONES = 3'b011,
      ALU_SUB = 3'b100,
      ALU_SUBC = 3'b101,
      ALU_SHL = 3'b110,
      ALU_SHR = 3'b111
   } alu_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } st_e;

endpackage

// File: verilog/flag_alu.sv
`timescale 1ns/100ps
`include "exec_cfg.svh"
module flag_alu import exec_pkg::*; (
   // Operation
   input alu_e op,
   // Operands and flags in
   input logic [7:0] a,
   input logic [7:0] b,
   input logic [7:0] flags_in,
   // Results
   output logic [7:0] res,
   output logic [7:0] flags_out
);

   function automatic logic [8:0] sub8(input logic [7:0] x, input logic [7:0] y, input logic cin);
      sub8 = {1'b0, x} - {1'b0, y} - {8'h00, cin};
   endfunction

   always_comb begin
      logic [8:0] d;
      logic [7:0] r;
      d = 9'h000;
      r = a;
      res = a;
      flags_out = flags_in;
      case (op)
         ALU_TEST: begin
            r = a & a;
            flags_out[`FLAG_Z] = (r == 8'h00);
            flags_out[`FLAG_N] = r[7];
            flags_out[`FLAG_V] = 1'b0;
         end
         ALU_CLEAR: begin
            r = a ^ a;
            res = r;
            flags_out[`FLAG_Z] = (r == 8'h00);
            flags_out[`FLAG_N] = r[7];
            flags_out[`FLAG_V] = 1'b0;
         end
         ALU_ONES: begin
            res = `ALL_ONES;
         end
         ALU_SUB, ALU_SUBC: begin
            // Result is discarded, only flags change
            d = sub8(a, b, (op == ALU_SUBC) & flags_in[`FLAG_C]);
            r = d[7:0];
            flags_out[`FLAG_C] = d[8];
            flags_out[`FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            flags_out[`FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
            flags_out[`FLAG_N] = r[7];
            // Chained zero so multi-byte compares work
            if (op == ALU_SUBC) begin
               flags_out[`FLAG_Z] = (r == 8'h00) & flags_in[`FLAG_Z];
            end else begin
               flags_out[`FLAG_Z] = (r == 8'h00);
            end
         end
         ALU_SHL: begin
            r = {a[6:0], 1'b0};
            res = r;
            flags_out[`FLAG_C] = a[7];
            flags_out[`FLAG_N] = r[7];
            flags_out[`FLAG_V] = r[7] ^ a[7];
            flags_out[`FLAG_Z] = (r == 8'h00);
         end
         ALU_SHR: begin
            r = {1'b0, a[7:1]};
            res = r;
            flags_out[`FLAG_C] = a[0];
            flags_out[`FLAG_N] = 1'b0;
            flags_out[`FLAG_V] = a[0];
            flags_out[`FLAG_Z] = (r == 8'h00);
         end
         default: begin
            res = a;
         end
      endcase
   end

endmodule

// File: verilog/branch_compare_skip_exec.sv
// What this block does
// - Register test ANDs the register with itself, sets Z, N and V, takes 1 cycle.
// - Clear XORs the register with itself setting Z, N, V; set-all-ones loads 0xff, no flags; 1 cycle each.
// - Relative jump goes to pc plus offset plus one, indirect jump to Z; 2 cycles, no flags.
// - Relative and indirect calls target likewise and push the return address; 3 cycles, no flags.
// - Compare-skip-equal skips the next instruction when both registers match; 1, 2 or 3 cycles.
// - Compares subtract register, register with carry, or immediate; only Z, N, V, C, H change; 1 cycle.
// - Register-bit skips skip when the chosen bit is clear or set; 1, 2 or 3 cycles, no flags.
// - I/O-bit skips skip when the chosen I/O register bit is clear or set; 1, 2 or 3 cycles.
// - Generic branches test a selected flag bit; 1 cycle untaken, 2 taken, target pc plus offset plus one.
// - Named flag branches act on Z, C, N, H, T or V set or clear the same way, no flag change.
// - Signed ge branches when N xor V is 0, signed lt when it is 1; 1 or 2 cycles.
// - Unsigned ge branches on carry clear, unsigned lt on carry set.
// - Interrupt-state branches go on the global enable flag set or clear.
// - I/O bit set and clear change one bit of an I/O register only, no flags, 2 cycles.
// - Logical shifts insert zero, update Z, C, N and V in 1 cycle.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "exec_cfg.svh"
module branch_compare_skip_exec import exec_pkg::*; #(
   parameter int PC_W = 16,
   parameter int DISP_W = 12,
   parameter int STACK_DEPTH = 16,
   parameter int IO_REGS = 32
) (
   // Clock and reset
   input logic pclk,
   input logic presetn,
   // APB slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   localparam int SP_W = $clog2(STACK_DEPTH);
   localparam int IOA_W = $clog2(IO_REGS);

   typedef struct packed {
      st_e st;
      logic [2:0] cnt;
      op_e op;
      logic [7:0] rd;
      logic [7:0] rr;
      logic [2:0] bsel;
      logic [IOA_W-1:0] ioa;
      logic two;
      logic [DISP_W-1:0] disp;
      logic [PC_W-1:0] pc;
      logic [PC_W-1:0] zp;
      logic [7:0] flags;
      logic [SP_W-1:0] sp;
      logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
      logic [IO_REGS-1:0][7:0] io;
      logic [PC_W-1:0] pc_p;
      logic [7:0] flags_p;
      logic [7:0] rd_p;
      logic io_wr_p;
      logic [7:0] io_p;
      logic push_p;
      logic pop_p;
      logic [2:0] last_cyc;
      logic bad;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_s;

   state_s s_r;
   state_s s_nxt;
   logic go;
   op_e go_op;
   alu_e alu_sel;
   logic [7:0] alu_res;
   logic [7:0] alu_flags;
   logic [PC_W-1:0] rel_now;
   logic busy;

   function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc, input logic [DISP_W-1:0] k);
      logic [PC_W-1:0] ext;
      ext = PC_W'($signed(k));
      rel_target = pc + ext + {{(PC_W-1){1'b0}}, 1'b1};
   endfunction

   function automatic alu_e alu_of(input op_e op);
      case (op)
         OP_TEST_REGISTER: alu_of = ALU_TEST;
         OP_CLEAR_REGISTER: alu_of = ALU_CLEAR;
         OP_SET_REGISTER_ALL_ONES: alu_of = ALU_ONES;
         OP_COMPARE_REGS: alu_of = ALU_SUB;
         OP_COMPARE_IMMEDIATE: alu_of = ALU_SUB;
         OP_COMPARE_REGS_WITH_CARRY: alu_of = ALU_SUBC;
         OP_SHIFT_LEFT_LOGICAL: alu_of = ALU_SHL;
         OP_SHIFT_RIGHT_LOGICAL: alu_of = ALU_SHR;
         default: alu_of = ALU_PASS;
      endcase
   endfunction

   // Refused writes were flagged in the cycle before, so the error and the effect agree
   assign go = psel & penable & s_r.pready & pwrite & ~s_r.pslverr & (paddr == `OFS_CTRL) & pwdata[`CTRL_GO_BIT];
   assign go_op = op_e'(pwdata[5:0]);
   assign alu_sel = alu_of(go_op);
   assign rel_now = rel_target(s_r.pc, s_r.disp);
   assign busy = (s_r.st == ST_RUN);

   // Immediate operand shares the second register slot
   flag_alu u_alu (
      .op(alu_sel),
      .a(s_r.rd),
      .b(s_r.rr),
      .flags_in(s_r.flags),
      .res(alu_res),
      .flags_out(alu_flags)
   );

   always_comb begin
      logic acc;
      logic wr;
      logic ok;
      logic [31:0] rdat;
      logic skip;
      logic take;
      logic is_skip;
      logic is_br;
      logic [2:0] cyc;
      s_nxt = s_r;
      acc = psel & penable & s_r.pready;
      wr = acc & pwrite & ~s_r.pslverr;
      ok = 1'b1;
      rdat = 32'h00000000;
      skip = 1'b0;
      take = 1'b0;
      is_skip = 1'b0;
      is_br = 1'b0;
      cyc = `CYC_ONE;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;

      // One wait state, then the answer
      case (paddr)
         `OFS_CTRL: rdat = {26'h0000000, s_r.op};
         `OFS_RD: rdat = {24'h000000, s_r.rd};
         `OFS_RR: rdat = {24'h000000, s_r.rr};
         `OFS_ARG: rdat = {15'h0000, s_r.two, (8 - IOA_W)'(0), s_r.ioa, 5'h00, s_r.bsel};
         `OFS_DISP: rdat = 32'(s_r.disp);
         `OFS_PC: rdat = 32'(s_r.pc);
         `OFS_ZP: rdat = 32'(s_r.zp);
         `OFS_FLAGS: rdat = {24'h000000, s_r.flags};
         `OFS_STAT: rdat = {23'h000000, s_r.bad, 1'b0, s_r.last_cyc, 3'h0, busy};
         `OFS_IODAT: rdat = {24'h000000, s_r.io[s_r.ioa]};
         `OFS_SP: rdat = 32'(s_r.sp);
         default: ok = 1'b0;
      endcase
      if (psel && penable && !s_r.pready) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = pwrite ? 32'h00000000 : rdat;
         // Writes during an operation would corrupt the pending commit
         s_nxt.pslverr = ~ok | (pwrite & busy);
      end

      if (wr) begin
         case (paddr)
            `OFS_CTRL: s_nxt.op = go_op;
            `OFS_RD: s_nxt.rd = pwdata[7:0];
            `OFS_RR: s_nxt.rr = pwdata[7:0];
            `OFS_ARG: begin
               s_nxt.bsel = pwdata[2:0];
               s_nxt.ioa = pwdata[`ARG_IO_LSB +: IOA_W];
               s_nxt.two = pwdata[`ARG_TWO_BIT];
            end
            `OFS_DISP: s_nxt.disp = pwdata[DISP_W-1:0];
            `OFS_PC: s_nxt.pc = pwdata[PC_W-1:0];
            `OFS_ZP: s_nxt.zp = pwdata[PC_W-1:0];
            `OFS_FLAGS: s_nxt.flags = pwdata[7:0];
            `OFS_IODAT: s_nxt.io[s_r.ioa] = pwdata[7:0];
            default: s_nxt.bad = s_r.bad;
         endcase
      end

      case (s_r.st)
         ST_IDLE: begin
            if (go) begin
               s_nxt.pc_p = s_r.pc + {{(PC_W-1){1'b0}}, 1'b1};
               s_nxt.flags_p = s_r.flags;
               s_nxt.rd_p = s_r.rd;
               s_nxt.io_wr_p = 1'b0;
               s_nxt.io_p = s_r.io[s_r.ioa];
               s_nxt.push_p = 1'b0;
               s_nxt.pop_p = 1'b0;
               s_nxt.bad = 1'b0;
               case (go_op)
                  OP_TEST_REGISTER, OP_CLEAR_REGISTER, OP_SET_REGISTER_ALL_ONES: begin
                     s_nxt.rd_p = alu_res;
                     s_nxt.flags_p = alu_flags;
                  end
                  OP_COMPARE_REGS, OP_COMPARE_REGS_WITH_CARRY, OP_COMPARE_IMMEDIATE: begin
                     s_nxt.flags_p = alu_flags;
                  end
                  OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL: begin
                     s_nxt.rd_p = alu_res;
                     s_nxt.flags_p = alu_flags;
                  end
                  OP_RELATIVE_JUMP: begin
                     s_nxt.pc_p = rel_now;
                     cyc = `CYC_TWO;
                  end
                  OP_INDIRECT_JUMP: begin
                     s_nxt.pc_p = s_r.zp;
                     cyc = `CYC_TWO;
                  end
                  OP_RELATIVE_CALL: begin
                     s_nxt.pc_p = rel_now;
                     s_nxt.push_p = 1'b1;
                     cyc = `CYC_THREE;
                  end
                  OP_INDIRECT_CALL: begin
                     s_nxt.pc_p = s_r.zp;
                     s_nxt.push_p = 1'b1;
                     cyc = `CYC_THREE;
                  end
                  OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN: begin
                     s_nxt.pc_p = s_r.stk[s_r.sp - 1'b1];
                     s_nxt.pop_p = 1'b1;
                     s_nxt.flags_p[`FLAG_I] = s_r.flags[`FLAG_I] | (go_op == OP_INTERRUPT_RETURN);
                     cyc = `CYC_FOUR;
                  end
                  OP_COMPARE_SKIP_EQUAL: begin
                     is_skip = 1'b1;
                     skip = (s_r.rd == s_r.rr);
                  end
                  OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET: begin
                     is_skip = 1'b1;
                     skip = s_r.rr[s_r.bsel] == (go_op == OP_SKIP_REG_BIT_SET);
                  end
                  OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
                     is_skip = 1'b1;
                     skip = s_r.io[s_r.ioa][s_r.bsel] == (go_op == OP_SKIP_IO_BIT_SET);
                  end
                  OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR: begin
                     // Named flag branches are these with a fixed flag index
                     is_br = 1'b1;
                     take = s_r.flags[s_r.bsel] == (go_op == OP_BRANCH_FLAG_SET);
                  end
                  OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT: begin
                     is_br = 1'b1;
                     take = (s_r.flags[`FLAG_N] ^ s_r.flags[`FLAG_V]) == (go_op == OP_BRANCH_SIGNED_LT);
                  end
                  OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT: begin
                     is_br = 1'b1;
                     take = s_r.flags[`FLAG_C] == (go_op == OP_BRANCH_UNSIGNED_LT);
                  end
                  OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED: begin
                     is_br = 1'b1;
                     take = s_r.flags[`FLAG_I] == (go_op == OP_BRANCH_IRQ_ENABLED);
                  end
                  OP_IO_BIT_SET_OP: begin
                     s_nxt.io_wr_p = 1'b1;
                     s_nxt.io_p[s_r.bsel] = 1'b1;
                     cyc = `CYC_TWO;
                  end
                  OP_IO_BIT_CLEAR_OP: begin
                     s_nxt.io_wr_p = 1'b1;
                     s_nxt.io_p[s_r.bsel] = 1'b0;
                     cyc = `CYC_TWO;
                  end
                  default: begin
                     s_nxt.bad = 1'b1;
                  end
               endcase
               if (is_skip && skip) begin
                  // Caller says how long the skipped instruction is
                  s_nxt.pc_p = s_r.pc + (s_r.two ? PC_W'(3) : PC_W'(2));
                  cyc = s_r.two ? `CYC_THREE : `CYC_TWO;
               end
               if (is_br && take) begin
                  s_nxt.pc_p = rel_now;
                  cyc = `CYC_TWO;
               end
               s_nxt.st = ST_RUN;
               s_nxt.cnt = cyc;
               s_nxt.last_cyc = cyc;
            end
         end
         ST_RUN: begin
            s_nxt.cnt = s_r.cnt - 1'b1;
            if (s_r.cnt == `CYC_ONE) begin
               s_nxt.st = ST_IDLE;
               s_nxt.pc = s_r.pc_p;
               s_nxt.flags = s_r.flags_p;
               s_nxt.rd = s_r.rd_p;
               if (s_r.io_wr_p) begin
                  s_nxt.io[s_r.ioa] = s_r.io_p;
               end
               // Stack wraps silently on overflow and underflow
               if (s_r.push_p) begin
                  s_nxt.stk[s_r.sp] = s_r.pc + {{(PC_W-1){1'b0}}, 1'b1};
                  s_nxt.sp = s_r.sp + 1'b1;
               end
               if (s_r.pop_p) begin
                  s_nxt.sp = s_r.sp - 1'b1;
               end
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.pc <= `RST_PC;
         s_r.flags <= `RST_FLAGS;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   test_flags_a: assert property (go && go_op == OP_TEST_REGISTER |-> ##2 s_r.rd == $past(s_r.rd, 2)
      && s_r.flags[`FLAG_Z] == ($past(s_r.rd, 2) == 8'h00) && !s_r.flags[`FLAG_V] && !busy)
      else $error("register test wrong");

   set_ones_a: assert property (go && go_op == OP_SET_REGISTER_ALL_ONES |-> ##2 s_r.rd == `ALL_ONES
      && s_r.flags == $past(s_r.flags, 2))
      else $error("set all ones wrong");

   jump_rel_a: assert property (go && go_op == OP_RELATIVE_JUMP |-> ##1 busy [*2] ##1 !busy
      && s_r.pc == $past(rel_now, 3))
      else $error("relative jump wrong");

   call_ind_a: assert property (go && go_op == OP_INDIRECT_CALL |-> ##4 s_r.pc == $past(s_r.zp, 4)
      && s_r.sp == $past(s_r.sp, 4) + 1'b1 && !busy)
      else $error("indirect call wrong");

   skip_equal_a: assert property (go && go_op == OP_COMPARE_SKIP_EQUAL && s_r.rd == s_r.rr && s_r.two
      |-> ##4 s_r.pc == $past(s_r.pc, 4) + PC_W'(3))
      else $error("skip length wrong");

   compare_flags_a: assert property (go && go_op == OP_COMPARE_REGS |-> ##2 s_r.rd == $past(s_r.rd, 2)
      && s_r.flags[`FLAG_C] == ($past(s_r.rd, 2) < $past(s_r.rr, 2))
      && s_r.flags[`FLAG_Z] == ($past(s_r.rd, 2) == $past(s_r.rr, 2)))
      else $error("compare flags wrong");

   io_noskip_a: assert property (go && go_op == OP_SKIP_IO_BIT_SET && !s_r.io[s_r.ioa][s_r.bsel]
      |-> ##2 s_r.pc == $past(s_r.pc, 2) + PC_W'(1) && !busy)
      else $error("io skip wrong");

   signed_lt_a: assert property (go && go_op == OP_BRANCH_SIGNED_LT
      && (s_r.flags[`FLAG_N] ^ s_r.flags[`FLAG_V]) |-> ##3 s_r.pc == $past(rel_now, 3))
      else $error("signed branch wrong");

   unsigned_ge_a: assert property (go && go_op == OP_BRANCH_UNSIGNED_GE && s_r.flags[`FLAG_C]
      |-> ##2 s_r.pc == $past(s_r.pc, 2) + PC_W'(1))
      else $error("unsigned branch wrong");

   io_bit_set_a: assert property (go && go_op == OP_IO_BIT_SET_OP |-> ##1 busy [*2] ##1
      s_r.io[s_r.ioa][s_r.bsel] && s_r.flags == $past(s_r.flags, 3))
      else $error("io bit set wrong");

   shift_right_a: assert property (go && go_op == OP_SHIFT_RIGHT_LOGICAL |-> ##2
      s_r.rd == ($past(s_r.rd, 2) >> 1) && s_r.flags[`FLAG_C] == $past(s_r.rd[0], 2))
      else $error("right shift wrong");

   irq_return_a: assert property (go && go_op == OP_INTERRUPT_RETURN |-> ##1 busy [*4] ##1
      !busy && s_r.flags[`FLAG_I])
      else $error("interrupt return wrong");

endmodule

// File: verification/branch_compare_skip_exec_tb.sv
`timescale 1ns/100ps
`include "exec_cfg.svh"
module branch_compare_skip_exec_tb import exec_pkg::*; ;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rv;
   logic pready;
   logic pslverr;
   logic ev;
   logic [7:0] f;
   int errors = 0;
   int samples_checked = 0;
   op_e bo[9] = '{OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_UNSIGNED_GE,
      OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT, OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED,
      OP_BRANCH_IRQ_DISABLED};
   logic [7:0] bf[9] = '{8'h0c, 8'h08, 8'h04, 8'h00, 8'h01, 8'h01, 8'h80, 8'h80, 8'h00};
   logic bt[9] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1};

   always #25 pclk = ~pclk;

   branch_compare_skip_exec u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );

   task finish_test;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] seen, input logic [31:0] x);
      samples_checked++;
      if (seen !== x) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, x, seen);
      end
   endtask

   // Entered just after a rising edge; transfers run back to back
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      // Read before the edge's updates land, so these are the values the edge samples
      while (pready !== 1'h1) @(posedge pclk);
      rv = prdata;
      ev = pslverr;
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk($sformatf("offset %h", a), rv, x);
   endtask

   task start(input op_e o);
      apb(1'h1, `OFS_CTRL, {23'h0, 1'h1, 2'h0, o});
   endtask

   task done(input logic [2:0] c);
      for (int i = 0; i < 8; i++) begin
         apb(1'h0, `OFS_STAT, 32'h0);
         if (rv[0] === 1'h0)
            break;
      end
      chk("cycles", {29'h0, rv[6:4]}, {29'h0, c});
   endtask

   task op(input op_e o, input logic [7:0] d, r, fl, input logic [16:0] g, input logic [11:0] k,
      input logic [15:0] p, input logic [2:0] c);
      apb(1'h1, `OFS_RD, {24'h0, d});
      apb(1'h1, `OFS_RR, {24'h0, r});
      apb(1'h1, `OFS_FLAGS, {24'h0, fl});
      apb(1'h1, `OFS_ARG, {15'h0, g});
      apb(1'h1, `OFS_DISP, {20'h0, k});
      apb(1'h1, `OFS_PC, {16'h0, p});
      start(o);
      done(c);
   endtask

   task res(input logic [15:0] p, input logic [7:0] fl, d);
      rdc(`OFS_PC, {16'h0, p});
      rdc(`OFS_FLAGS, {24'h0, fl});
      rdc(`OFS_RD, {24'h0, d});
   endtask

   initial begin
      #(50 * 20000);
      errors++;
      finish_test;
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      res(16'h0000, 8'h00, 8'h00);
      rdc(`OFS_SP, 32'h0);
      apb(1'h0, 8'h3c, 32'h0);
      chk("unmapped error", {31'h0, ev}, 32'h1);
      op(OP_TEST_REGISTER, 8'h80, 8'h00, 8'h00, 17'h0, 12'h0, 16'h0000, 3'h1);
      res(16'h0001, 8'h04, 8'h80);
      op(OP_TEST_REGISTER, 8'h00, 8'h00, 8'h08, 17'h0, 12'h0, 16'h0000, 3'h1);
      res(16'h0001, 8'h02, 8'h00);
      op(OP_CLEAR_REGISTER, 8'h5a, 8'h00, 8'h0c, 17'h0, 12'h0, 16'h0000, 3'h1);
      res(16'h0001, 8'h02, 8'h00);
      op(OP_SET_REGISTER_ALL_ONES, 8'h12, 8'h00, 8'h2f, 17'h0, 12'h0, 16'h0000, 3'h1);
      res(16'h0001, 8'h2f, 8'hff);
      op(OP_RELATIVE_JUMP, 8'h00, 8'h00, 8'h5a, 17'h0, 12'hffe, 16'h0010, 3'h2);
      res(16'h000f, 8'h5a, 8'h00);
      apb(1'h1, `OFS_ZP, 32'h1234);
      op(OP_INDIRECT_JUMP, 8'h00, 8'h00, 8'h5a, 17'h0, 12'h0, 16'h0010, 3'h2);
      res(16'h1234, 8'h5a, 8'h00);
      op(OP_INDIRECT_CALL, 8'h00, 8'h00, 8'h00, 17'h0, 12'h0, 16'h0010, 3'h3);
      res(16'h1234, 8'h00, 8'h00);
      op(OP_RELATIVE_CALL, 8'h00, 8'h00, 8'h00, 17'h0, 12'h005, 16'h0020, 3'h3);
      res(16'h0026, 8'h00, 8'h00);
      rdc(`OFS_SP, 32'h2);
      // Write lands while the four-cycle return is still busy
      start(OP_INTERRUPT_RETURN);
      apb(1'h1, `OFS_ZP, 32'h0);
      chk("busy write error", {31'h0, ev}, 32'h1);
      done(3'h4);
      res(16'h0021, 8'h80, 8'h00);
      start(OP_SUBROUTINE_RETURN);
      done(3'h4);
      res(16'h0011, 8'h80, 8'h00);
      rdc(`OFS_SP, 32'h0);
      op(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 8'h00, 17'h10000, 12'h0, 16'h0040, 3'h3);
      res(16'h0043, 8'h00, 8'h33);
      op(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h34, 8'h00, 17'h10000, 12'h0, 16'h0040, 3'h1);
      res(16'h0041, 8'h00, 8'h33);
      op(OP_COMPARE_REGS, 8'h10, 8'h20, 8'h50, 17'h0, 12'h0, 16'h0000, 3'h1);
      res(16'h0001, 8'h55, 8'h10);
      op(OP_COMPARE_IMMEDIATE, 8'h10, 8'h20, 8'h50, 17'h0, 12'h0, 16'h0000, 3'h1);
      res(16'h0001, 8'h55, 8'h10);
      op(OP_COMPARE_REGS_WITH_CARRY, 8'h20, 8'h1f, 8'h03, 17'h0, 12'h0, 16'h0000, 3'h1);
      res(16'h0001, 8'h22, 8'h20);
      op(OP_SKIP_REG_BIT_SET, 8'h00, 8'h20, 8'h5a, 17'h00005, 12'h0, 16'h0040, 3'h2);
      res(16'h0042, 8'h5a, 8'h00);
      op(OP_SKIP_REG_BIT_CLEAR, 8'h00, 8'h20, 8'h5a, 17'h00005, 12'h0, 16'h0040, 3'h1);
      res(16'h0041, 8'h5a, 8'h00);
      apb(1'h1, `OFS_ARG, 32'h0305);
      apb(1'h1, `OFS_IODAT, 32'h00);
      op(OP_IO_BIT_SET_OP, 8'h00, 8'h00, 8'h5a, 17'h00305, 12'h0, 16'h0040, 3'h2);
      rdc(`OFS_IODAT, 32'h20);
      rdc(`OFS_FLAGS, 32'h5a);
      op(OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 8'h00, 17'h10305, 12'h0, 16'h0040, 3'h3);
      res(16'h0043, 8'h00, 8'h00);
      op(OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h00, 17'h10305, 12'h0, 16'h0040, 3'h1);
      res(16'h0041, 8'h00, 8'h00);
      apb(1'h1, `OFS_IODAT, 32'hff);
      op(OP_IO_BIT_CLEAR_OP, 8'h00, 8'h00, 8'h00, 17'h00305, 12'h0, 16'h0040, 3'h2);
      rdc(`OFS_IODAT, 32'hdf);
      op(OP_SHIFT_LEFT_LOGICAL, 8'h81, 8'h00, 8'h00, 17'h0, 12'h0, 16'h0000, 3'h1);
      res(16'h0001, 8'h09, 8'h02);
      op(OP_SHIFT_RIGHT_LOGICAL, 8'h01, 8'h00, 8'h00, 17'h0, 12'h0, 16'h0000, 3'h1);
      res(16'h0001, 8'h0b, 8'h00);
      // Undefined code acts as a one-cycle step and is flagged
      start(op_e'(6'h3f));
      done(3'h1);
      chk("undefined op", {31'h0, rv[8]}, 32'h1);
      rdc(`OFS_PC, 32'h2);
      for (int s = 0; s < 8; s++) begin
         f = 8'h01 << s;
         op(OP_BRANCH_FLAG_SET, 8'h00, 8'h00, f, {14'h0, 3'(s)}, 12'h010, 16'h0100, 3'h2);
         res(16'h0111, f, 8'h00);
         op(OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, f, {14'h0, 3'(s)}, 12'h010, 16'h0100, 3'h1);
         res(16'h0101, f, 8'h00);
         op(OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, ~f, {14'h0, 3'(s)}, 12'h010, 16'h0100, 3'h2);
         res(16'h0111, ~f, 8'h00);
      end
      // Negative offset exercises sign extension of the displacement
      for (int i = 0; i < 9; i++) begin
         op(bo[i], 8'h00, 8'h00, bf[i], 17'h0, 12'hff0, 16'h0100, bt[i] ? 3'h2 : 3'h1);
         res(bt[i] ? 16'h00f1 : 16'h0101, bf[i], 8'h00);
      end
      finish_test;
   end
endmodule
